/* design/rssa_defines.svh */
// Constants of the serial slave front end: slave address, memory map, FIFO and timing counts.
// Assumes a 100 MHz core clock; included by the package, the serial slave module and the bench.
`ifndef RSSA_DEFINES_SVH
`define RSSA_DEFINES_SVH

// Seven address bits of the slave address byte D0h (direction bit excluded)
`define RSSA_SLAVE_ADDR 7'h68
`define RSSA_PTR_W 6
`define RSSA_MEM_BYTES 64
`define RSSA_CLOCK_BYTES 8
`define RSSA_FIFO_DEPTH 4
`define RSSA_BIT_CNT_W 4
`define RSSA_BYTE_BITS 4'h8
`define RSSA_PTR_RST 6'h00
`define RSSA_MEM_RST 8'h00
// Sync reset order {scl, sda, power fail, below switchover, external select_n}
`define RSSA_SYNC_RST 5'h19

`define RSSA_CLK_PERIOD_NS 10
// Recovery hold after supply returns, in microseconds; least time, rounded up
`define RSSA_REC_HOLD_US 1000
`define RSSA_REC_HOLD_CYC ((`RSSA_REC_HOLD_US * 1000 + `RSSA_CLK_PERIOD_NS - 1) / `RSSA_CLK_PERIOD_NS)

`endif

/* design/rssa_pkg.sv */
// Types of the serial slave front end: transfer states and the write record.
// Assumes rssa_defines.svh is on the include path.
`include "rssa_defines.svh"

package rssa_pkg;

  typedef enum logic [3:0] {
    TS_IDLE      = 4'b0000,
    TS_ADDR      = 4'b0001,
    TS_ADDR_ACK  = 4'b0010,
    TS_WADDR     = 4'b0011,
    TS_WADDR_ACK = 4'b0100,
    TS_WDATA     = 4'b0101,
    TS_WDATA_ACK = 4'b0110,
    TS_RDATA     = 4'b0111,
    TS_RACK      = 4'b1000
  } rssa_state_t;

  typedef struct packed {
    logic [`RSSA_PTR_W-1:0] addr;
    logic [7:0] data;
  } rssa_wr_t;

endpackage

/* design/rssa_pin_sync.sv */
// Two-flop synchroniser for pins, plus one more stage so the user can find edges.
// Assumes inputs are asynchronous to core_clk_i; only the second stage and later are read.
`timescale 1ns/100ps
`default_nettype none

module rssa_pin_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] lvl_o,
  output logic [WIDTH-1:0] prev_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] lvl_r;
  logic [WIDTH-1:0] prev_r;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= RST_VAL;
      lvl_r <= RST_VAL;
      prev_r <= RST_VAL;
    end else begin
      meta_r <= async_i;
      lvl_r <= meta_r;
      prev_r <= lvl_r;
    end
  end

  assign lvl_o = lvl_r;
  assign prev_o = prev_r;

endmodule

`default_nettype wire

/* design/rssa_fifo.sv */
// Small synchronous FIFO in flip-flops with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock domain.
`timescale 1ns/100ps
`default_nettype none

module rssa_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;

  wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire empty = (wr_ptr_r == rd_ptr_r);
  wire push = in_valid_i && !full;
  wire pop = out_ready_i && !empty;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
      rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
    end
  end

  // Storage needs no reset; valid only flags written slots
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
    end
  end

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];

endmodule

`default_nettype wire

/* design/rssa_serial_slave.sv */
// Two-wire serial slave front end of a clock/supervisor: 64-byte space, pointer, power-fail gating.
// Assumes SCL/SDA and supply comparator levels arrive asynchronously; time bytes and the write
// consumer run on core_clk_i. SDA and reset are driven low by the pad while the enable is high; select drives its level.
`timescale 1ns/100ps
`default_nettype none
`include "rssa_defines.svh"

module rssa_serial_slave import rssa_pkg::*; #(
  parameter int REC_HOLD_CYC = `RSSA_REC_HOLD_CYC
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic below_power_fail_threshold_i,
  input wire logic below_battery_switchover_threshold_i,
  input wire logic ext_select_n_i,
  output logic gated_sram_select_n_o,
  output logic gated_sram_select_n_oe_o,
  output logic sys_rst_n_o,
  output logic sys_rst_n_oe_o,
  input wire logic [8*`RSSA_CLOCK_BYTES-1:0] live_time_i,
  input wire logic time_tick_i,
  output logic clock_copy_hold_o,
  output rssa_wr_t wr_o,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [`RSSA_PTR_W-1:0] word_pointer_value_o
);

  function automatic logic is_clock_addr(input logic [`RSSA_PTR_W-1:0] a);
    is_clock_addr = (a < `RSSA_PTR_W'(`RSSA_CLOCK_BYTES));
  endfunction

  // Pin synchronisers
  logic [4:0] pin_lvl;
  logic [4:0] pin_prev;

  rssa_pin_sync #(
    .WIDTH(5),
    .RST_VAL(`RSSA_SYNC_RST)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .async_i({scl_i, sda_i, below_power_fail_threshold_i, below_battery_switchover_threshold_i,
              ext_select_n_i}),
    .lvl_o(pin_lvl),
    .prev_o(pin_prev)
  );

  wire scl_s = pin_lvl[4];
  wire scl_p = pin_prev[4];
  wire sda_s = pin_lvl[3];
  wire sda_p = pin_prev[3];
  wire pf_s = pin_lvl[2];
  wire batt_s = pin_lvl[1];
  wire ext_sel_n_s = pin_lvl[0];

  wire scl_rise = scl_s && !scl_p;
  wire scl_fall = !scl_s && scl_p;
  // Sampling both lines through equal-length syncs keeps start/stop ordering intact
  wire start_det = scl_s && scl_p && sda_p && !sda_s;
  wire stop_det = scl_s && scl_p && !sda_p && sda_s;

  // Supply supervision
  logic [31:0] rec_cnt_r;
  wire recovering = (rec_cnt_r != 32'h0000_0000);
  wire supply_bad = pf_s || recovering;
  wire blocked = supply_bad || batt_s;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rec_cnt_r <= 32'h0000_0000;
    end else if (pf_s) begin
      rec_cnt_r <= 32'(REC_HOLD_CYC);
    end else if (recovering) begin
      rec_cnt_r <= rec_cnt_r - 32'h0000_0001;
    end
  end

  // Reset stays asserted through the outage and the recovery hold unless on battery
  assign sys_rst_n_o = 1'b0;
  assign sys_rst_n_oe_o = supply_bad && !batt_s;
  // Select is forced inactive high; the pad stops driving once on battery
  assign gated_sram_select_n_o = supply_bad ? 1'b1 : ext_sel_n_s;
  assign gated_sram_select_n_oe_o = !batt_s;

  // Transfer engine
  rssa_state_t state_r;
  rssa_state_t state_nxt;
  logic [`RSSA_BIT_CNT_W-1:0] bit_r;
  logic [`RSSA_BIT_CNT_W-1:0] bit_nxt;
  logic [7:0] rx_r;
  logic [7:0] rx_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic [`RSSA_PTR_W-1:0] ptr_r;
  logic [`RSSA_PTR_W-1:0] ptr_nxt;
  logic oe_r;
  logic oe_nxt;
  logic rw_r;
  logic rw_nxt;
  logic mack_r;
  logic mack_nxt;
  logic push;
  logic fifo_in_ready;
  logic [7:0] mem_r [`RSSA_MEM_BYTES];

  wire byte_done = (bit_r == `RSSA_BYTE_BITS);
  wire rx_state = (state_r == TS_ADDR) || (state_r == TS_WADDR) || (state_r == TS_WDATA);
  wire addr_match = (rx_r[7:1] == `RSSA_SLAVE_ADDR);
  wire [7:0] rd_byte = mem_r[ptr_r];
  wire [`RSSA_PTR_W-1:0] ptr_inc = ptr_r + `RSSA_PTR_W'(1);

  always_comb begin
    state_nxt = state_r;
    bit_nxt = bit_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    oe_nxt = oe_r;
    rw_nxt = rw_r;
    mack_nxt = mack_r;
    push = 1'b0;
    if (pf_s) begin
      // Abort, forget the pointer and stay deaf while the supply is low
      state_nxt = TS_IDLE;
      oe_nxt = 1'b0;
      ptr_nxt = `RSSA_PTR_RST;
      bit_nxt = '0;
    end else if (blocked) begin
      state_nxt = TS_IDLE;
      oe_nxt = 1'b0;
      bit_nxt = '0;
    end else if (stop_det) begin
      state_nxt = TS_IDLE;
      oe_nxt = 1'b0;
    end else if (start_det) begin
      // Also covers a repeated start in the middle of a transfer
      state_nxt = TS_ADDR;
      bit_nxt = '0;
      oe_nxt = 1'b0;
    end else if (scl_rise) begin
      if (rx_state) begin
        rx_nxt = {rx_r[6:0], sda_s};
        bit_nxt = bit_r + `RSSA_BIT_CNT_W'(1);
      end else if (state_r == TS_RDATA) begin
        bit_nxt = bit_r + `RSSA_BIT_CNT_W'(1);
      end else if (state_r == TS_WDATA_ACK) begin
        ptr_nxt = ptr_inc;
      end else if (state_r == TS_RACK) begin
        mack_nxt = !sda_s;
        if (!sda_s) begin
          ptr_nxt = ptr_inc;
        end
      end
    end else if (scl_fall) begin
      // SDA is only pulled low here, with SCL already low; aborts, starts and stops release it
      unique case (state_r)
        TS_IDLE: begin
        end
        TS_ADDR: begin
          if (byte_done) begin
            if (addr_match) begin
              state_nxt = TS_ADDR_ACK;
              oe_nxt = 1'b1;
              rw_nxt = rx_r[0];
            end else begin
              state_nxt = TS_IDLE;
            end
          end
        end
        TS_ADDR_ACK: begin
          bit_nxt = '0;
          if (rw_r) begin
            // Read starts from whatever the pointer holds
            state_nxt = TS_RDATA;
            tx_nxt = rd_byte;
            oe_nxt = !rd_byte[7];
          end else begin
            state_nxt = TS_WADDR;
            oe_nxt = 1'b0;
          end
        end
        TS_WADDR: begin
          if (byte_done) begin
            ptr_nxt = rx_r[`RSSA_PTR_W-1:0];
            state_nxt = TS_WADDR_ACK;
            oe_nxt = 1'b1;
          end
        end
        TS_WADDR_ACK: begin
          state_nxt = TS_WDATA;
          bit_nxt = '0;
          oe_nxt = 1'b0;
        end
        TS_WDATA: begin
          if (byte_done) begin
            if (fifo_in_ready) begin
              push = 1'b1;
              state_nxt = TS_WDATA_ACK;
              oe_nxt = 1'b1;
            end else begin
              // A full write buffer refuses the byte rather than lose it silently
              state_nxt = TS_IDLE;
            end
          end
        end
        TS_WDATA_ACK: begin
          state_nxt = TS_WDATA;
          bit_nxt = '0;
          oe_nxt = 1'b0;
        end
        TS_RDATA: begin
          if (byte_done) begin
            state_nxt = TS_RACK;
            oe_nxt = 1'b0;
          end else begin
            tx_nxt = {tx_r[6:0], 1'b0};
            oe_nxt = !tx_r[6];
          end
        end
        TS_RACK: begin
          bit_nxt = '0;
          if (mack_r) begin
            state_nxt = TS_RDATA;
            tx_nxt = rd_byte;
            oe_nxt = !rd_byte[7];
          end else begin
            // No acknowledge: line stays released until the master stops
            state_nxt = TS_IDLE;
            oe_nxt = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= TS_IDLE;
      bit_r <= '0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= `RSSA_PTR_RST;
      oe_r <= 1'b0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_r <= bit_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      oe_r <= oe_nxt;
      rw_r <= rw_nxt;
      mack_r <= mack_nxt;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_r && !batt_s;
  assign word_pointer_value_o = ptr_r;

  // Clock copy freezes while a transfer is open and the pointer is on a clock byte, so a stop releases it
  wire hold = (state_r != TS_IDLE) && is_clock_addr(ptr_r);
  assign clock_copy_hold_o = hold;

  // Write buffer toward the timekeeping side
  rssa_wr_t wr_in;
  rssa_wr_t wr_q;
  logic wr_q_valid;

  assign wr_in.addr = ptr_r;
  assign wr_in.data = rx_r;

  rssa_fifo #(
    .WIDTH($bits(rssa_wr_t)),
    .DEPTH(`RSSA_FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .in_data_i(wr_in),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .out_data_o(wr_q),
    .out_valid_o(wr_q_valid),
    .out_ready_i(wr_ready_i)
  );

  assign wr_o = wr_q;
  assign wr_valid_o = wr_q_valid;
  wire drain_fire = wr_q_valid && wr_ready_i;

  // Byte space: clock bytes take the live time unless frozen; a drained write wins
  for (genvar i = 0; i < `RSSA_MEM_BYTES; i++) begin : g_mem
    wire wr_hit = drain_fire && (wr_q.addr == `RSSA_PTR_W'(i));
    if (i < `RSSA_CLOCK_BYTES) begin : g_clk
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          mem_r[i] <= `RSSA_MEM_RST;
        end else if (wr_hit) begin
          mem_r[i] <= wr_q.data;
        end else if (time_tick_i && !hold) begin
          mem_r[i] <= live_time_i[8*i +: 8];
        end
      end
    end else begin : g_ram
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          mem_r[i] <= `RSSA_MEM_RST;
        end else if (wr_hit) begin
          mem_r[i] <= wr_q.data;
        end
      end
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_start_enters_addr:
    assert property (start_det && !blocked && !stop_det |=> state_r == TS_ADDR && !oe_r)
    else $error("start did not enter address phase");

  a_stop_ends_xfer:
    assert property (stop_det |=> state_r == TS_IDLE && !sda_oe_o)
    else $error("stop did not end transfer");

  a_pf_clears_ptr:
    assert property (pf_s |=> ptr_r == `RSSA_PTR_RST && state_r == TS_IDLE)
    else $error("power fail did not abort and clear pointer");

  a_rst_on_pf:
    assert property (pf_s && !batt_s |-> sys_rst_n_oe_o ##1 (sys_rst_n_oe_o || batt_s))
    else $error("reset not asserted during power fail");

  a_sram_gated:
    assert property (pf_s |-> gated_sram_select_n_o)
    else $error("sram select not held inactive");

  a_rec_hold:
    assert property ($fell(pf_s) |-> rec_cnt_r == 32'(REC_HOLD_CYC) ##1 (recovering && gated_sram_select_n_o))
    else $error("recovery hold not started");

  a_ack_word_addr:
    assert property ($rose(state_r == TS_WADDR_ACK) |-> oe_r && ptr_r == $past(rx_r[`RSSA_PTR_W-1:0]))
    else $error("word address not loaded and acknowledged");

  a_foreign_nack:
    assert property (state_r == TS_ADDR && scl_fall && byte_done && !addr_match && !blocked
                     && !start_det && !stop_det |=> state_r == TS_IDLE && !oe_r)
    else $error("foreign address acknowledged");

  a_read_advance:
    assert property (state_r == TS_RACK && scl_rise && !sda_s && !blocked && !start_det && !stop_det
                     |=> ptr_r == $past(ptr_inc))
    else $error("pointer not advanced on acknowledge");

  a_hold_clock:
    assert property (state_r != TS_IDLE && ptr_r < `RSSA_PTR_W'(`RSSA_CLOCK_BYTES) |-> clock_copy_hold_o)
    else $error("clock copy not halted");

  a_tick_frozen:
    assert property (time_tick_i && clock_copy_hold_o && !drain_fire |=> mem_r[0] == $past(mem_r[0]))
    else $error("clock byte copied while halted");

  a_hiz_battery:
    assert property (batt_s |-> !sda_oe_o && !sys_rst_n_oe_o && !gated_sram_select_n_oe_o)
    else $error("outputs driven on battery");

endmodule

`default_nettype wire

/* sim/rssa_master_model.sv */
// Behavioural two-wire bus master: drives SCL and pulls SDA low, read data is strobed out.
// Assumes a pull-up on SDA resolved by the bench; tasks are called hierarchically.
`timescale 1ns/100ps
`default_nettype none

module rssa_master_model (
  input wire logic core_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o,
  output logic [7:0] rd_byte_o,
  output logic rd_stb_o
);
  // Quarter bit in core cycles; 4 gives the 160 ns link period, more stalls the bus
  int q = 4;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    rd_byte_o = 8'h00;
    rd_stb_o = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // SCL stands high between frames, so a first start always meets an idle bus
  task automatic start();
    wt(q);
    sda_low_o <= 1'b0;
    wt(q);
    scl_o <= 1'b1;
    wt(q);
    sda_low_o <= 1'b1;
    wt(q);
    scl_o <= 1'b0;
  endtask

  task automatic stop();
    wt(q);
    sda_low_o <= 1'b1;
    wt(q);
    scl_o <= 1'b1;
    wt(q);
    sda_low_o <= 1'b0;
    wt(2 * q);
  endtask

  // Data moves mid-low and is sampled mid-high: one SCL pulse per bit
  task automatic bit_cyc(input logic low, output logic s);
    wt(q);
    sda_low_o <= low;
    wt(q);
    scl_o <= 1'b1;
    wt(q);
    s = sda_i;
    wt(q);
    scl_o <= 1'b0;
  endtask

  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(!b[i], s);
    end
    bit_cyc(1'b0, s);
    ack = !s;
  endtask

  task automatic read_byte(input logic ack);
    logic [7:0] d;
    logic s;
    for (int i = 0; i < 8; i++) begin
      bit_cyc(1'b0, s);
      d = {d[6:0], s};
    end
    bit_cyc(ack, s);
    rd_byte_o <= d;
    rd_stb_o <= 1'b1;
    wt(1);
    rd_stb_o <= 1'b0;
  endtask
endmodule

`default_nettype wire

/* sim/rssa_serial_slave_bench.sv */
// Self-checking bench of the serial slave front end, with the bus master model.
// Assumes the design's own assertions run alongside; the recovery hold is shortened.
`timescale 1ns/100ps
`default_nettype none
`include "rssa_defines.svh"
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); \
  end \
end

module rssa_serial_slave_bench import rssa_pkg::*;;
  localparam int REC = 20;
  logic clk, nrst, pf, bs, ext_n, tick, wr_ready, a;
  logic [63:0] live;
  logic scl, sda, m_low, sda_oe, sel_n, sel_oe, rst_oe, hold, wr_valid, rd_stb;
  logic sda_out, rst_out;
  logic [7:0] rd_byte, er;
  logic [5:0] ptr, ep;
  rssa_wr_t wr, ew;
  rssa_wr_t wq[$];
  logic [7:0] rq[$];
  logic [7:0] mem[64];
  logic [31:0] seed = 32'hba19_1985;
  int bad_count = 0;
  int tests_run = 0;

  // Open drain with pull-up: low when either party pulls
  assign sda = !m_low && (sda_oe ? sda_out : 1'b1);
  wire rst_pin = rst_oe ? rst_out : 1'b1;

  rssa_serial_slave #(.REC_HOLD_CYC(REC)) dut (.core_clk_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_out), .sda_oe_o(sda_oe), .below_power_fail_threshold_i(pf), .below_battery_switchover_threshold_i(bs),
    .ext_select_n_i(ext_n), .gated_sram_select_n_o(sel_n), .gated_sram_select_n_oe_o(sel_oe), .sys_rst_n_o(rst_out),
    .sys_rst_n_oe_o(rst_oe), .live_time_i(live), .time_tick_i(tick), .clock_copy_hold_o(hold), .wr_o(wr),
    .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .word_pointer_value_o(ptr));

  rssa_master_model m (.core_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low), .rd_byte_o(rd_byte),
    .rd_stb_o(rd_stb));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic wr_hdr(input logic [7:0] waddr);
    m.start();
    m.write_byte(8'hD0, a);
    `CHK(a, 1'b1)
    m.write_byte(waddr, a);
    `CHK(a, 1'b1)
    ep = waddr[5:0];
    `CHK(ptr, ep)
  endtask

  task automatic put(input logic [7:0] d, input logic ok);
    // With wr_ready high the write drains before the acknowledge bit ends, so note it first
    if (ok) begin
      wq.push_back('{addr: ep, data: d});
    end
    m.write_byte(d, a);
    `CHK(a, ok)
    if (ok) begin
      mem[ep] = d;
      ep = ep + 6'h01;
    end
  endtask

  task automatic rd_sess(input int n);
    m.start();
    m.write_byte(8'hD1, a);
    `CHK(a, 1'b1)
    for (int i = 1; i <= n; i++) begin
      rq.push_back(mem[ep]);
      m.read_byte(i < n);
      if (i < n) begin
        ep = ep + 6'h01;
      end
    end
    m.stop();
    `CHK(ptr, ep)
  endtask

  task automatic pulse_tick();
    seed = lfsr(seed);
    live <= {seed, ~seed};
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Results are taken off the queues in the order they were noted
  always @(posedge clk) begin
    if (wr_valid && wr_ready) begin
      ew = wq.pop_front();
      `CHK(wr, ew)
    end
    if (rd_stb) begin
      er = rq.pop_front();
      `CHK(rd_byte, er)
    end
  end

  // About 5200 cycles of traffic expected; the limit leaves almost six times that
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    final_report();
  end

  initial begin
    nrst = 1'b0;
    pf = 1'b0;
    bs = 1'b0;
    ext_n = 1'b1;
    tick = 1'b0;
    wr_ready = 1'b1;
    live = 64'h0000_0000_0000_0000;
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'h00;
    end
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    wr_hdr(8'h3E);
    repeat (4) begin
      seed = lfsr(seed);
      put(seed[7:0], 1'b1);
    end
    `CHK(ptr, ep)
    m.stop();
    done("write wrap");
    wr_ready <= 1'b0;
    wr_hdr(8'h30);
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      put(seed[7:0], i < 4);
    end
    m.stop();
    `CHK(wr_valid, 1'b1)
    wr_ready <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(wr_valid, 1'b0)
    done("fifo full");
    wr_hdr(8'h3E);
    rd_sess(3);
    rd_sess(1);
    done("reads");
    pulse_tick();
    for (int i = 0; i < 8; i++) begin
      mem[i] = live[8*i +: 8];
    end
    wr_hdr(8'h06);
    `CHK(hold, 1'b1)
    pulse_tick();
    rd_sess(3);
    `CHK(hold, 1'b0)
    done("copy hold");
    m.start();
    m.write_byte(8'hA0, a);
    `CHK(a, 1'b0)
    m.write_byte(8'hD0, a);
    `CHK(a, 1'b0)
    m.stop();
    done("foreign address");
    ext_n <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(sel_n, 1'b0)
    m.start();
    m.write_byte(8'hD0, a);
    pf <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(rst_oe, 1'b1)
    `CHK(rst_pin, 1'b0)
    `CHK(sel_n, 1'b1)
    `CHK(ptr, 6'h00)
    m.write_byte(8'h10, a);
    `CHK(a, 1'b0)
    m.stop();
    pf <= 1'b0;
    repeat (REC - 5) @(posedge clk);
    `CHK(rst_oe, 1'b1)
    `CHK(sel_n, 1'b1)
    repeat (15) @(posedge clk);
    `CHK(rst_oe, 1'b0)
    `CHK(sel_n, 1'b0)
    wr_hdr(8'h12);
    m.stop();
    done("power fail");
    pf <= 1'b1;
    bs <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(sda_oe, 1'b0)
    `CHK(sel_oe, 1'b0)
    `CHK(rst_oe, 1'b0)
    `CHK(rst_pin, 1'b1)
    pf <= 1'b0;
    bs <= 1'b0;
    repeat (REC + 10) @(posedge clk);
    `CHK(sel_oe, 1'b1)
    done("battery");
    final_report();
  end
endmodule

`default_nettype wire
